//--- design/pcs_core.sv
// program counter, return stack, table read and alu status core
`timescale 1ns/1ps
// What this block does
// - keep 11-bit pc for 2K program words
// - advance pc by one otherwise
// - reset loads 000h, interrupt loads 004h
// - call and goto load instruction low bits
// - returns pop stack top into pc
// - counter low byte readable, writable, mirrored fourfold
// - high view reads pc high bits only
// - writing 1Ch sets select flag, else clears
// - flag clear: low write loads latch high
// - flag set: low write keeps pc high
// - eight-level 12-bit stack, push and pop
// - table ops fetch pointer word byte
// - table result writes 01h/02h trigger reads
// - 8-bit alu: add, sub, shift, logic
// - subtraction carries are inverted borrows
// - flag results override status writes
// - status bank select bits for addressing
// - timeout flag set, cleared by ops
// - power-down flag set by sleep
// - zero flag follows result zero
// - digit carry from low nibble
// - carry from most significant bit
module pcs_core
    import pcs_pkg::*;
#(
    parameter int unsigned STACK_LEVELS = STK_DEPTH
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_sys_rst,
    input  wire logic             i_por,        // power-on reset qualifier
    input  wire pcs_exec_t        i_exec,
    input  wire logic             i_wdt_timeout,
    input  wire logic [8:0]       i_rd_addr,
    input  wire logic [7:0]       i_table_ptr,  // pointer low byte
    input  wire logic [7:0]       i_table_ptr_h,// pointer high byte
    input  wire logic [15:0]      i_rom_data,   // word at o_rom_addr
    output logic      [10:0]      o_pc,
    output logic      [15:0]      o_rom_addr,
    output logic      [7:0]       o_rd_data,
    output logic                  o_rd_hit,
    output logic      [7:0]       o_alu_result,
    output logic      [7:0]       o_w_load,     // byte bound for w
    output logic                  o_w_load_en,
    output logic      [1:0]       o_direct_bank,
    output logic                  o_indirect_bank
);
    localparam int unsigned SP_W = $clog2(STACK_LEVELS);

    initial begin
        if (STACK_LEVELS < 2 || (STACK_LEVELS & (STACK_LEVELS - 1)) != 0)
            $error("stack levels must be a power of two of at least two");
    end

    // =========================================================
    // state
    // =========================================================
    typedef struct packed {
        logic [10:0]       pc;
        logic [SP_W-1:0]   sp;
        logic [7:0]        status;
        logic [7:0]        latch;
        logic              high_sel;
        logic [7:0]        tab;
        logic              tab_pend;   // table fetch waits one cycle
        logic              tab_hi;
        logic [15:0]       rom_addr;
        logic [7:0]        rd_data;
        logic              rd_hit;
        logic [7:0]        alu;
        logic [7:0]        w_load;
        logic              w_load_en;
    } pcs_state_t;

    pcs_state_t s_q, s_d;
    logic [STK_W-1:0] stack_q [STACK_LEVELS];
    logic             push;
    logic [STK_W-1:0] push_val;

    // alu scratch
    logic [8:0]  sum;
    logic [4:0]  nib;
    logic [7:0]  res;
    logic        c_out;
    logic        dc_out;
    logic        hit_lo, hit_st, hit_la, hit_hv, hit_tb;
    logic [10:0] pc_inc;
    logic [7:0]  st_next;

    // =========================================================
    // alu
    // =========================================================
    // an 8-bit datapath; carry in for shifts comes from status
    always_comb begin
        sum    = 9'h000;
        nib    = 5'h00;
        res    = i_exec.opb;
        c_out  = s_q.status[ST_C];
        dc_out = s_q.status[ST_DC];
        unique case (i_exec.alu_op)
            PCS_ALU_ADD: begin
                sum    = {1'b0, i_exec.opa} + {1'b0, i_exec.opb};
                nib    = {1'b0, i_exec.opa[3:0]} + {1'b0, i_exec.opb[3:0]};
                res    = sum[7:0];
                c_out  = sum[8];
                dc_out = nib[4];
            end
            PCS_ALU_SUB: begin
                // opb minus opa; the carry is the inverted borrow
                sum    = {1'b0, i_exec.opb} + {1'b0, ~i_exec.opa} + 9'h001;
                nib    = {1'b0, i_exec.opb[3:0]} + {1'b0, ~i_exec.opa[3:0]}
                       + 5'h01;
                res    = sum[7:0];
                c_out  = sum[8];
                dc_out = nib[4];
            end
            PCS_ALU_AND: res = i_exec.opa & i_exec.opb;
            PCS_ALU_OR:  res = i_exec.opa | i_exec.opb;
            PCS_ALU_XOR: res = i_exec.opa ^ i_exec.opb;
            PCS_ALU_RLC: begin
                res   = {i_exec.opb[6:0], s_q.status[ST_C]};
                c_out = i_exec.opb[7];
            end
            PCS_ALU_RRC: begin
                res   = {s_q.status[ST_C], i_exec.opb[7:1]};
                c_out = i_exec.opb[0];
            end
            PCS_ALU_PASS: res = i_exec.opb;
        endcase
    end

    // file register decode; the low byte and status mirror in every bank
    assign hit_lo = i_exec.wr_en && i_exec.wr_addr[6:0] == BANK_OFS_MASKED_LO;
    assign hit_st = i_exec.wr_en && i_exec.wr_addr[6:0] == BANK_OFS_MASKED_ST;
    assign hit_la = i_exec.wr_en && i_exec.wr_addr[6:0] == BANK_OFS_MASKED_LA;
    assign hit_hv = i_exec.wr_en && i_exec.wr_addr == ADDR_HIGH_VIEW;
    assign hit_tb = i_exec.wr_en && i_exec.wr_addr == ADDR_TABLE_RESULT;
    assign pc_inc = s_q.pc + 11'h001;

    // =========================================================
    // next state
    // =========================================================
    always_comb begin
        logic [7:0] wdat;
        wdat      = i_exec.alu_en ? res : i_exec.wr_data;
        s_d       = s_q;
        push      = 1'b0;
        push_val  = {1'b0, pc_inc};
        s_d.w_load_en = 1'b0;
        st_next   = s_q.status;

        // program flow
        if (i_exec.valid) begin
            s_d.pc = pc_inc;
            unique case (i_exec.flow)
                PCS_FLOW_NEXT, PCS_FLOW_TABL, PCS_FLOW_TABH: ;
                PCS_FLOW_GOTO: s_d.pc = i_exec.word[10:0];
                PCS_FLOW_CALL: begin
                    push   = 1'b1;
                    s_d.pc = i_exec.word[10:0];
                end
                PCS_FLOW_RET: begin
                    s_d.sp = s_q.sp - 1'b1;
                    s_d.pc = stack_q[s_q.sp - 1'b1][10:0];
                end
                PCS_FLOW_IRQ: begin
                    // interrupt saves the current pc, it was not executed
                    push     = 1'b1;
                    push_val = {1'b0, s_q.pc};
                    s_d.pc   = PC_IRQ_VEC;
                end
                default: ;
            endcase
            if (push) begin
                s_d.sp = s_q.sp + 1'b1;
            end
            // table fetch by op or by the result register
            if (i_exec.flow == PCS_FLOW_TABL ||
                    i_exec.flow == PCS_FLOW_TABH) begin
                s_d.tab_pend = 1'b1;
                s_d.tab_hi   = i_exec.flow == PCS_FLOW_TABH;
            end
        end

        // file register writes
        if (hit_lo) begin
            s_d.pc[7:0] = wdat;
            if (!s_q.high_sel) begin
                s_d.pc[10:8] = s_q.latch[2:0];
            end else begin
                // undo any carry that the increment above put into the page
                s_d.pc[10:8] = s_q.pc[10:8];
            end
        end
        if (hit_la) begin
            s_d.latch = wdat;
        end
        if (hit_hv) begin
            s_d.high_sel = wdat == HIGH_SEL_KEY;
        end
        if (hit_tb && (wdat == TABLE_CMD_LOW || wdat == TABLE_CMD_HIGH)) begin
            s_d.tab_pend = 1'b1;
            s_d.tab_hi   = wdat == TABLE_CMD_HIGH;
        end
        if (hit_st) begin
            st_next = (wdat & ST_SW_MASK) | (s_q.status & ~ST_SW_MASK);
        end
        // flags written by the instruction win over its own status write
        if (i_exec.valid && i_exec.alu_en) begin
            if (i_exec.flag_z) begin
                st_next[ST_Z] = res == 8'h00;
            end
            if (i_exec.flag_cd) begin
                st_next[ST_C]  = c_out;
                st_next[ST_DC] = dc_out;
            end
        end
        // timeout set wins over the clearing ops
        if (i_exec.valid && (i_exec.wdt_clear || i_exec.sleep)) begin
            st_next[ST_TO] = 1'b0;
        end
        if (i_exec.valid && i_exec.wdt_clear) begin
            st_next[ST_PD] = 1'b0;
        end
        if (i_exec.valid && i_exec.sleep) begin
            st_next[ST_PD] = 1'b1;
        end
        if (i_wdt_timeout) begin
            st_next[ST_TO] = 1'b1;
        end
        s_d.status = st_next;

        // table fetch completes one cycle after the address is out
        s_d.rom_addr = {i_table_ptr_h, i_table_ptr};
        if (s_q.tab_pend) begin
            s_d.tab_pend  = 1'b0;
            s_d.tab       = s_q.tab_hi ? i_rom_data[15:8] : i_rom_data[7:0];
            s_d.w_load    = s_d.tab;
            s_d.w_load_en = 1'b1;
        end

        // read path
        s_d.alu    = res;
        s_d.rd_hit = 1'b1;
        unique case (1'b1)
            i_rd_addr[6:0] == BANK_OFS_MASKED_LO: s_d.rd_data = s_q.pc[7:0];
            i_rd_addr[6:0] == BANK_OFS_MASKED_ST: s_d.rd_data = s_q.status;
            i_rd_addr[6:0] == BANK_OFS_MASKED_LA: s_d.rd_data = s_q.latch;
            i_rd_addr == ADDR_HIGH_VIEW:
                s_d.rd_data = {5'h00, s_q.pc[10:8]};
            i_rd_addr == ADDR_TABLE_RESULT: s_d.rd_data = s_q.tab;
            default: begin
                s_d.rd_data = 8'h00;
                s_d.rd_hit  = 1'b0;
            end
        endcase
    end

    // =========================================================
    // registers
    // =========================================================
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            s_q          <= '0;
            s_q.pc       <= PC_RESET_VEC;
            s_q.high_sel <= 1'b0;
            s_q.status   <= ST_RESET;
            if (!i_por) begin
                // warm resets keep to and pd so software can tell the cause
                s_q.status[ST_TO] <= s_q.status[ST_TO];
                s_q.status[ST_PD] <= s_q.status[ST_PD];
            end
        end else begin
            s_q <= s_d;
        end
    end

    // stack body has no reset; pointer reset is enough
    always_ff @(posedge i_clk_sys) begin
        if (push) begin
            stack_q[s_q.sp] <= push_val;
        end
    end

    assign o_pc            = s_q.pc;
    assign o_rom_addr      = s_q.rom_addr;
    assign o_rd_data       = s_q.rd_data;
    assign o_rd_hit        = s_q.rd_hit;
    assign o_alu_result    = s_q.alu;
    assign o_w_load        = s_q.w_load;
    assign o_w_load_en     = s_q.w_load_en;
    assign o_direct_bank   = s_q.status[ST_RP0 +: 2];
    assign o_indirect_bank = s_q.status[ST_IRP];
endmodule // pcs_core

//--- design/pcs_pkg.sv
// package for the program sequencing core: register map, opcodes, carriers
package pcs_pkg;
    localparam int unsigned PC_W      = 11;
    localparam int unsigned STK_W     = 12;
    localparam int unsigned STK_DEPTH = 8;
    localparam logic [10:0] PC_RESET_VEC = 11'h000;
    localparam logic [10:0] PC_IRQ_VEC   = 11'h004;
    // register offsets (9-bit file address); low seven bits pick the mirror
    localparam logic [8:0] ADDR_COUNTER_LOW   = 9'h002;
    localparam logic [8:0] ADDR_FLAGS_BANK    = 9'h003;
    localparam logic [8:0] ADDR_HIGH_LATCH    = 9'h00a;
    localparam logic [8:0] ADDR_HIGH_VIEW     = 9'h10c;
    localparam logic [8:0] ADDR_TABLE_RESULT  = 9'h18c;
    localparam logic [6:0] BANK_OFS_MASKED_LO = 7'h02;
    localparam logic [6:0] BANK_OFS_MASKED_ST = 7'h03;
    localparam logic [6:0] BANK_OFS_MASKED_LA = 7'h0a;
    localparam logic [7:0] HIGH_SEL_KEY       = 8'h1c;
    localparam logic [7:0] TABLE_CMD_LOW      = 8'h01;
    localparam logic [7:0] TABLE_CMD_HIGH     = 8'h02;
    // status field positions
    localparam int unsigned ST_C    = 0;
    localparam int unsigned ST_DC   = 1;
    localparam int unsigned ST_Z    = 2;
    localparam int unsigned ST_PD   = 3;
    localparam int unsigned ST_TO   = 4;
    localparam int unsigned ST_RP0  = 5;
    localparam int unsigned ST_IRP  = 7;
    localparam logic [7:0] ST_RESET = 8'h00;
    localparam logic [7:0] ST_SW_MASK = 8'he7; // to and pd are read only

    // program flow operation issued with each executed instruction
    typedef enum logic [2:0] {
        PCS_FLOW_NEXT  = 3'b000,
        PCS_FLOW_GOTO  = 3'b001,
        PCS_FLOW_CALL  = 3'b010,
        PCS_FLOW_RET   = 3'b011,
        PCS_FLOW_IRQ   = 3'b100,
        PCS_FLOW_TABL  = 3'b101,
        PCS_FLOW_TABH  = 3'b110
    } pcs_flow_t;

    // alu operations
    typedef enum logic [2:0] {
        PCS_ALU_ADD = 3'b000,
        PCS_ALU_SUB = 3'b001,
        PCS_ALU_AND = 3'b010,
        PCS_ALU_OR  = 3'b011,
        PCS_ALU_XOR = 3'b100,
        PCS_ALU_RLC = 3'b101,
        PCS_ALU_RRC = 3'b110,
        PCS_ALU_PASS = 3'b111
    } pcs_alu_op_t;

    // one executed instruction as seen by the core
    typedef struct packed {
        logic        valid;     // instruction retires this cycle
        pcs_flow_t   flow;
        logic [15:0] word;      // instruction word
        logic        alu_en;    // alu result goes to a file register or w
        pcs_alu_op_t alu_op;
        logic [7:0]  opa;       // usually w
        logic [7:0]  opb;       // file register or literal
        logic        flag_z;    // instruction updates zero
        logic        flag_cd;   // instruction updates carry and digit carry
        logic        wr_en;     // file register write
        logic [8:0]  wr_addr;
        logic [7:0]  wr_data;   // used when alu_en is clear
        logic        wdt_clear; // watchdog clear op
        logic        sleep;     // sleep op
    } pcs_exec_t;
endpackage

//--- tb/pcs_rom_model.sv
// program memory model answering the core's table fetch address
`timescale 1ns/1ps
// ====
// program memory
module pcs_rom_model (
    input  wire logic [15:0] i_addr,
    output logic      [15:0] o_data
);
    // the low byte depends on both address bytes, the high byte on the low address byte only, so a lane swap shows up
    assign o_data = {i_addr[7:0] ^ 8'h3c, i_addr[15:8] + i_addr[7:0]};
endmodule // pcs_rom_model

//--- tb/pcs_core_monitor.sv
// assertion checker for the sequencing core ports
`timescale 1ns/1ps
// ====
// checker
module pcs_core_monitor
    import pcs_pkg::*;
#(
    parameter int unsigned STACK_LEVELS = STK_DEPTH
) (
    input wire logic        i_clk_sys,
    input wire logic        i_sys_rst,
    input wire logic        i_por,
    input wire pcs_exec_t   i_exec,
    input wire logic        i_wdt_timeout,
    input wire logic [8:0]  i_rd_addr,
    input wire logic [7:0]  i_table_ptr,
    input wire logic [7:0]  i_table_ptr_h,
    input wire logic [15:0] i_rom_data,
    input wire logic [10:0] o_pc,
    input wire logic [15:0] o_rom_addr,
    input wire logic [7:0]  o_rd_data,
    input wire logic        o_rd_hit,
    input wire logic [7:0]  o_alu_result,
    input wire logic [7:0]  o_w_load,
    input wire logic        o_w_load_en,
    input wire logic [1:0]  o_direct_bank,
    input wire logic        o_indirect_bank
);
    logic vld, wr_tab, tab_lo, tab_hi, mapped;
    // table requests come from a flow code or a result register write
    assign vld = i_exec.valid;
    assign wr_tab = vld && i_exec.wr_en && !i_exec.alu_en
        && i_exec.wr_addr == ADDR_TABLE_RESULT;
    assign tab_lo = vld && i_exec.flow == PCS_FLOW_TABL
        || wr_tab && i_exec.wr_data == TABLE_CMD_LOW;
    assign tab_hi = vld && i_exec.flow == PCS_FLOW_TABH
        || wr_tab && i_exec.wr_data == TABLE_CMD_HIGH;
    assign mapped = i_rd_addr[6:0] inside {BANK_OFS_MASKED_LO,
        BANK_OFS_MASKED_ST, BANK_OFS_MASKED_LA}
        || i_rd_addr inside {ADDR_HIGH_VIEW, ADDR_TABLE_RESULT};
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);
    sequence s_call; vld && i_exec.flow == PCS_FLOW_CALL; endsequence
    sequence s_ret; vld && i_exec.flow == PCS_FLOW_RET; endsequence
    a_reset_clears_pc: assert property ($fell(i_sys_rst) |->
        o_pc == PC_RESET_VEC && !o_w_load_en && o_direct_bank == 2'b00)
        else $error("pc not cleared by reset");
    a_next_increments: assert property (vld
        && i_exec.flow == PCS_FLOW_NEXT && !i_exec.wr_en
        |=> o_pc == $past(o_pc) + 11'h001) else $error("pc not advanced");
    a_jump_target: assert property (vld && i_exec.flow inside
        {PCS_FLOW_GOTO, PCS_FLOW_CALL} |=> o_pc == $past(i_exec.word[10:0]))
        else $error("jump target wrong");
    a_irq_vector: assert property (vld
        && i_exec.flow == PCS_FLOW_IRQ |=> o_pc == PC_IRQ_VEC)
        else $error("interrupt vector wrong");
    a_call_return: assert property (s_call ##2 s_ret
        |=> o_pc == $past(o_pc, 3) + 11'h001) else $error("bad return");
    a_table_addr: assert property (tab_lo || tab_hi |=>
        o_rom_addr == {$past(i_table_ptr_h), $past(i_table_ptr)})
        else $error("table address wrong");
    a_table_low: assert property (tab_lo |-> ##2 o_w_load_en
        && o_w_load == $past(i_rom_data[7:0])) else $error("low byte");
    a_table_high: assert property (tab_hi |-> ##2 o_w_load_en
        && o_w_load == $past(i_rom_data[15:8])) else $error("high byte");
    a_bank_write: assert property (vld && i_exec.wr_en
        && !i_exec.alu_en && i_exec.wr_addr[6:0] == BANK_OFS_MASKED_ST
        |=> {o_indirect_bank, o_direct_bank} == $past(i_exec.wr_data[7:5]))
        else $error("bank select not written");
    a_read_hit: assert property (1'b1 |=> o_rd_hit == $past(mapped)
        && (o_rd_hit || o_rd_data == 8'h00)) else $error("read decode");
endmodule // pcs_core_monitor
bind pcs_core pcs_core_monitor #(.STACK_LEVELS(STACK_LEVELS))
    pcs_core_monitor_inst (.*);

//--- tb/testbench.sv
// self-checking bench for the sequencing core
`timescale 1ns/1ps
// ====
// bench
module testbench;
    import pcs_pkg::*;
    logic        i_clk_sys = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic        i_por = 1'b1;
    pcs_exec_t   i_exec = '0;
    logic        i_wdt_timeout = 1'b0;
    logic [8:0]  i_rd_addr = 9'h000;
    logic [7:0]  i_table_ptr = 8'h00;
    logic [7:0]  i_table_ptr_h = 8'h00;
    logic [15:0] i_rom_data, o_rom_addr;
    logic [10:0] o_pc;
    logic [7:0]  o_rd_data, o_alu_result, o_w_load;
    logic        o_rd_hit, o_w_load_en, o_indirect_bank;
    logic [1:0]  o_direct_bank;
    int          err_total = 0;
    int          checks = 0;
    int          cyc = 0;
    logic [10:0] m_pc, m_stk[$];
    logic [7:0]  m_st, m_lat, m_tab;
    logic        m_hsel;
    pcs_core #(.STACK_LEVELS(STK_DEPTH)) pcs_core_inst (.*);
    pcs_rom_model pcs_rom_model_inst (.i_addr(o_rom_addr), .o_data(i_rom_data));
    // 250 MHz clock, and a ceiling far beyond the short test sequence
    always #2 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 4000) begin
            err_total++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        if (err_total == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic cmp_pc(input logic [10:0] got, input logic [10:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t pc %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t byte %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [8:0] a, input logic [7:0] e, input logic h);
        @(negedge i_clk_sys) i_rd_addr = a;
        @(negedge i_clk_sys);
        cmp_byte(o_rd_data, e);
        cmp_byte({7'h00, o_rd_hit}, {7'h00, h});
    endtask
    // the oldest return address is lost once the stack overflows
    task automatic push(input logic [10:0] v);
        m_stk.push_back(v);
        if (m_stk.size() > STK_DEPTH) void'(m_stk.pop_front());
    endtask
    function automatic pcs_exec_t mk(input pcs_flow_t f, input logic [15:0] w);
        pcs_exec_t e;
        e = '0;
        e.valid = 1'b1;
        e.flow = f;
        e.word = w;
        return e;
    endfunction
    // issue one instruction, update the model, compare pc and results
    task automatic run(input pcs_exec_t ex);
        logic [8:0]  r;
        logic [7:0]  wd, msk;
        logic [10:0] old;
        logic        dc, tq, hi;
        r = {m_st[ST_C], 8'h00};
        dc = m_st[ST_DC];
        tq = ex.flow inside {PCS_FLOW_TABL, PCS_FLOW_TABH};
        hi = ex.flow == PCS_FLOW_TABH;
        old = m_pc;
        @(negedge i_clk_sys) i_exec = ex;
        @(negedge i_clk_sys) i_exec = '0;
        case (ex.alu_op)
            PCS_ALU_ADD: begin
                r = {1'b0, ex.opa} + {1'b0, ex.opb};
                dc = ({1'b0, ex.opa[3:0]} + {1'b0, ex.opb[3:0]}) > 5'h0f;
            end
            PCS_ALU_SUB: begin
                r = {ex.opb >= ex.opa, ex.opb - ex.opa};
                dc = ex.opb[3:0] >= ex.opa[3:0];
            end
            PCS_ALU_AND: r[7:0] = ex.opa & ex.opb;
            PCS_ALU_OR:  r[7:0] = ex.opa | ex.opb;
            PCS_ALU_XOR: r[7:0] = ex.opa ^ ex.opb;
            PCS_ALU_RLC: r = {ex.opb, m_st[ST_C]};
            PCS_ALU_RRC: r = {ex.opb[0], m_st[ST_C], ex.opb[7:1]};
            default:     r[7:0] = ex.opb;
        endcase
        wd = ex.alu_en ? r[7:0] : ex.wr_data;
        msk = ST_SW_MASK & ~{5'h00, ex.flag_z, {2{ex.flag_cd}}};
        m_pc = old + 11'h001;
        case (ex.flow)
            PCS_FLOW_GOTO: m_pc = ex.word[10:0];
            PCS_FLOW_CALL: begin
                push(old + 11'h001);
                m_pc = ex.word[10:0];
            end
            PCS_FLOW_RET: m_pc = m_stk.pop_back();
            PCS_FLOW_IRQ: begin
                push(old);
                m_pc = PC_IRQ_VEC;
            end
            default: ;
        endcase
        if (ex.wr_en && ex.wr_addr[6:0] == BANK_OFS_MASKED_LO)
            m_pc = {m_hsel ? old[10:8] : m_lat[2:0], wd};
        if (ex.wr_en && ex.wr_addr[6:0] == BANK_OFS_MASKED_ST)
            m_st = (m_st & ~msk) | (wd & msk);
        if (ex.wr_en && ex.wr_addr[6:0] == BANK_OFS_MASKED_LA) m_lat = wd;
        if (ex.wr_en && ex.wr_addr == ADDR_HIGH_VIEW)
            m_hsel = wd == HIGH_SEL_KEY;
        if (ex.wr_en && ex.wr_addr == ADDR_TABLE_RESULT
            && wd inside {TABLE_CMD_LOW, TABLE_CMD_HIGH}) begin
            tq = 1'b1;
            hi = wd == TABLE_CMD_HIGH;
        end
        if (ex.flag_z) m_st[ST_Z] = r[7:0] == 8'h00;
        if (ex.flag_cd) m_st[1:0] = {dc, r[8]};
        if (ex.wdt_clear || ex.sleep) m_st[ST_TO] = 1'b0;
        if (ex.wdt_clear || ex.sleep) m_st[ST_PD] = ex.sleep;
        cmp_pc(o_pc, m_pc);
        if (ex.alu_en) cmp_byte(o_alu_result, r[7:0]);
        if (tq) begin
            @(negedge i_clk_sys);
            m_tab = hi ? i_table_ptr ^ 8'h3c : i_table_ptr_h + i_table_ptr;
            cmp_byte({7'h00, o_w_load_en}, 8'h01);
            cmp_byte(o_w_load, m_tab);
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        pcs_exec_t e;
        e = mk(PCS_FLOW_NEXT, 16'h0000);
        e.wr_en = 1'b1;
        e.wr_addr = a;
        e.wr_data = d;
        run(e);
    endtask
    task automatic alu(input pcs_alu_op_t op, input logic [7:0] a, b,
                       input logic w);
        pcs_exec_t e;
        e = mk(PCS_FLOW_NEXT, 16'h0000);
        e.alu_en = 1'b1;
        e.alu_op = op;
        e.opa = a;
        e.opb = b;
        e.flag_z = 1'b1;
        e.flag_cd = op inside {PCS_ALU_ADD, PCS_ALU_SUB};
        e.wr_en = w;
        e.wr_addr = 9'h083;
        run(e);
    endtask
    task automatic wdt_pulse();
        @(negedge i_clk_sys) i_wdt_timeout = 1'b1;
        @(negedge i_clk_sys) i_wdt_timeout = 1'b0;
        m_st[ST_TO] = 1'b1;
    endtask
    // main sequence: reset values, flow, stack, latch, table, flags
    initial begin
        pcs_exec_t  ex;
        logic [7:0] a, b;
        logic [8:0] ra [5];
        ra = '{9'h002, 9'h003, 9'h00a, 9'h10c, 9'h18c};
        void'($urandom(32'h9f65));
        m_pc = PC_RESET_VEC;
        m_st = ST_RESET;
        m_lat = 8'h00;
        m_tab = 8'h00;
        m_hsel = 1'b0;
        repeat (3) @(negedge i_clk_sys);
        i_sys_rst = 1'b0;
        foreach (ra[i]) rd(ra[i], 8'h00, 1'b1);
        rd(9'h004, 8'h00, 1'b0);
        repeat (3 + $urandom % 6) run(mk(PCS_FLOW_NEXT, 16'h0000));
        rd(9'h182, m_pc[7:0], 1'b1);
        run(mk(PCS_FLOW_GOTO, 16'($urandom)));
        wr(ADDR_HIGH_VIEW, 8'h07);
        rd(ADDR_HIGH_VIEW, {5'h00, m_pc[10:8]}, 1'b1);
        repeat (9) run(mk(PCS_FLOW_CALL, 16'($urandom)));
        repeat (8) run(mk(PCS_FLOW_RET, 16'h0000));
        run(mk(PCS_FLOW_IRQ, 16'h0000));
        run(mk(PCS_FLOW_RET, 16'h0000));
        wr(9'h08a, 8'($urandom));
        wr(9'h002, 8'hfe);
        wr(ADDR_HIGH_VIEW, HIGH_SEL_KEY);
        wr(9'h182, 8'($urandom));
        wr(ADDR_HIGH_VIEW, 8'h1d);
        wr(9'h102, 8'($urandom));
        i_table_ptr = 8'($urandom);
        i_table_ptr_h = 8'($urandom);
        wr(ADDR_TABLE_RESULT, TABLE_CMD_LOW);
        wr(ADDR_TABLE_RESULT, TABLE_CMD_HIGH);
        wr(ADDR_TABLE_RESULT, TABLE_CMD_LOW);
        rd(ADDR_TABLE_RESULT, m_tab, 1'b1);
        run(mk(PCS_FLOW_TABL, 16'h0000));
        run(mk(PCS_FLOW_TABH, 16'h0000));
        for (int i = 0; i < 16; i++) begin
            a = (i == 8) ? 8'hff : 8'($urandom);
            b = (i == 8) ? 8'h01 : (i == 9) ? a : 8'($urandom);
            alu(pcs_alu_op_t'(3'(i)), a, b, 1'b0);
            rd(ADDR_FLAGS_BANK, m_st, 1'b1);
        end
        wr(ADDR_FLAGS_BANK, 8'hff);
        cmp_byte({5'h00, o_indirect_bank, o_direct_bank}, m_st >> 5);
        alu(PCS_ALU_ADD, 8'h80, 8'h80, 1'b1);
        rd(ADDR_FLAGS_BANK, m_st, 1'b1);
        wdt_pulse();
        ex = mk(PCS_FLOW_NEXT, 16'h0000);
        ex.sleep = 1'b1;
        run(ex);
        rd(ADDR_FLAGS_BANK, m_st, 1'b1);
        wdt_pulse();
        // warm reset: pc and banks clear, to and pd survive
        @(negedge i_clk_sys) {i_sys_rst, i_por} = 2'b10;
        @(negedge i_clk_sys) {i_sys_rst, i_por} = 2'b01;
        m_pc = PC_RESET_VEC;
        m_st = m_st & 8'h18;
        rd(ADDR_FLAGS_BANK, m_st, 1'b1);
        ex.sleep = 1'b0;
        ex.wdt_clear = 1'b1;
        run(ex);
        rd(ADDR_FLAGS_BANK, m_st, 1'b1);
        print_verdict();
    end
endmodule // testbench
